//--- hbi_pkg.sv
package hbi_pkg;
   // ------------------------------------------------------------
   // Widths and address map
   // ------------------------------------------------------------
   localparam int          HBI_ADDR_W    = 17;
   localparam int          HBI_DATA_W    = 16;
   localparam int          HBI_BE_W      = 2;
   localparam logic [16:0] HBI_MEM_FIRST = 17'h00000;
   localparam logic [16:0] HBI_MEM_LAST  = 17'h13FFF;
   localparam logic [16:0] HBI_REG_FIRST = 17'h1FFE0;
   localparam logic [16:0] HBI_REG_LAST  = 17'h1FFFF;

   // ------------------------------------------------------------
   // Synchronised strobe vector layout (all active low)
   // ------------------------------------------------------------
   localparam int         HBI_STRB_W   = 5;
   localparam int         HBI_SB_CS    = 0;
   localparam int         HBI_SB_WR_LO = 1;
   localparam int         HBI_SB_HI    = 2;
   localparam int         HBI_SB_RD_LO = 3;
   localparam int         HBI_SB_RD_HI = 4;
   localparam logic [4:0] HBI_STRB_IDLE = 5'h1F;
   localparam int         HBI_SYNC_STAGES = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] HBI_DATA_RST = 16'h0000;
   localparam logic [16:0] HBI_ADDR_RST = 17'h00000;
   localparam logic [1:0]  HBI_BE_RST   = 2'h0;

   // ------------------------------------------------------------
   // Access sequencer states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      HBI_ST_IDLE = 4'h1,
      HBI_ST_REQ  = 4'h2,
      HBI_ST_RDW  = 4'h4,
      HBI_ST_DONE = 4'h8
   } hbi_state_t;
endpackage : hbi_pkg

//--- hbi_sync.sv
`timescale 1ns/1ps
module hbi_sync #(
   parameter int            W       = 5,
   parameter logic [W-1:0]  RST_VAL = '1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   // ------------------------------------------------------------
   // Two-stage synchroniser
   // ------------------------------------------------------------
   always_comb begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end

   assign q_out = q_r;
endmodule : hbi_sync

//--- hbi_host_if.sv
`timescale 1ns/1ps
// Summary of operation
// - Every access uses a sixteen bit data path to the host.
// - Mode one: chip select plus separate read and write strobes per byte.
// - Mode two: shared high byte enable, separate low read and write strobes.
// - Strap low selects mode one, high selects mode two; no bus use.
// - Host side runs on its own bus clock, apart from display clock.
// - Seventeen bit byte address and sixteen data lines are taken.
// - Wait stays low until read data valid or write data accepted.
// - On collision with refresh, wait stays low until arbitration grants host.
// - Mode two: upper strobe is high byte enable for reads and writes.
// - Strobes and chip select arrive asynchronously and are synchronised.
// - Memory at 0 to 13FFFh, registers at 1FFE0h to 1FFFFh.
module hbi_host_if
   import hbi_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire logic                          mode_strap_n,
   input  wire logic                          endian_strap,
   input  wire logic [hbi_pkg::HBI_ADDR_W-1:1] host_addr_in,
   input  wire logic                          host_addr_lsb,
   input  wire logic [hbi_pkg::HBI_DATA_W-1:0] host_data_in,
   output logic      [hbi_pkg::HBI_DATA_W-1:0] host_data_out,
   output logic                               host_data_oe,
   input  wire logic                          chip_select_n,
   input  wire logic                          low_byte_write_n,
   input  wire logic                          high_byte_strobe_n,
   input  wire logic                          low_byte_read_n,
   input  wire logic                          high_byte_read_n,
   output logic                               wait_n,
   output logic                               acc_req,
   output logic                               acc_write,
   output logic                               acc_reg,
   output logic      [hbi_pkg::HBI_ADDR_W-1:0] acc_addr,
   output logic      [hbi_pkg::HBI_BE_W-1:0]   acc_be,
   output logic      [hbi_pkg::HBI_DATA_W-1:0] acc_wdata,
   input  wire logic                          acc_grant,
   input  wire logic [hbi_pkg::HBI_DATA_W-1:0] acc_rdata,
   input  wire logic                          acc_rvalid
);
   import hbi_pkg::*;

   function automatic logic [15:0] swap16(input logic [15:0] d, input logic en);
      swap16 = en ? {d[7:0], d[15:8]} : d;
   endfunction : swap16

   // ------------------------------------------------------------
   // Strobe synchronisation
   // ------------------------------------------------------------
   logic [HBI_STRB_W-1:0] strb_raw;
   logic [HBI_STRB_W-1:0] strb_s;

   assign strb_raw = {high_byte_read_n, low_byte_read_n, high_byte_strobe_n,
                      low_byte_write_n, chip_select_n};

   hbi_sync #(
      .W       (HBI_STRB_W),
      .RST_VAL (HBI_STRB_IDLE)
   ) u_sync (
      .clk   (clk),
      .rstn  (rstn),
      .d_in  (strb_raw),
      .q_out (strb_s)
   );

   // ------------------------------------------------------------
   // Strap capture after reset release
   // ------------------------------------------------------------
   logic strap_taken_r;
   logic strap_taken_nxt;
   logic mode2_r;
   logic mode2_nxt;
   logic big_r;
   logic big_nxt;

   always_comb begin
      strap_taken_nxt = 1'b1;
      mode2_nxt       = strap_taken_r ? mode2_r : mode_strap_n;
      big_nxt         = strap_taken_r ? big_r : endian_strap;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_taken_r <= 1'b0;
         mode2_r       <= 1'b0;
         big_r         <= 1'b0;
      end else begin
         strap_taken_r <= strap_taken_nxt;
         mode2_r       <= mode2_nxt;
         big_r         <= big_nxt;
      end
   end

   // ------------------------------------------------------------
   // Strobe decode per interface mode
   // ------------------------------------------------------------
   logic        cs_act;
   logic        rd_act;
   logic        wr_act;
   logic [1:0]  host_be;
   logic [16:0] full_addr;
   logic        is_mem;
   logic        is_reg;

   always_comb begin
      cs_act = !strb_s[HBI_SB_CS];
      if (mode2_r) begin
         // Upper read strobe is ignored here
         wr_act  = !strb_s[HBI_SB_WR_LO];
         rd_act  = !strb_s[HBI_SB_RD_LO];
         host_be = {!strb_s[HBI_SB_HI], !host_addr_lsb};
      end else begin
         wr_act  = !strb_s[HBI_SB_WR_LO] || !strb_s[HBI_SB_HI];
         rd_act  = !strb_s[HBI_SB_RD_LO] || !strb_s[HBI_SB_RD_HI];
         host_be = {!strb_s[HBI_SB_HI] || !strb_s[HBI_SB_RD_HI],
                    !strb_s[HBI_SB_WR_LO] || !strb_s[HBI_SB_RD_LO]};
      end
      full_addr = {host_addr_in, host_addr_lsb};
      is_mem    = (full_addr <= HBI_MEM_LAST);
      is_reg    = (full_addr >= HBI_REG_FIRST);
   end

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   hbi_state_t  state_r;
   hbi_state_t  state_nxt;
   logic        start;
   logic        req_r;
   logic        req_nxt;
   logic        write_r;
   logic        write_nxt;
   logic        reg_r;
   logic        reg_nxt;
   logic [16:0] addr_r;
   logic [16:0] addr_nxt;
   logic [1:0]  be_r;
   logic [1:0]  be_nxt;
   logic [15:0] wdata_r;
   logic [15:0] wdata_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic        oe_r;
   logic        oe_nxt;
   logic        wait_n_r;
   logic        wait_n_nxt;

   assign start = cs_act && (rd_act || wr_act) && strap_taken_r;

   always_comb begin
      state_nxt = state_r;
      req_nxt   = req_r;
      write_nxt = write_r;
      reg_nxt   = reg_r;
      addr_nxt  = addr_r;
      be_nxt    = be_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      unique case (state_r)
         HBI_ST_IDLE: begin
            if (start) begin
               write_nxt = wr_act;
               reg_nxt   = is_reg;
               addr_nxt  = full_addr;
               be_nxt    = big_r ? {host_be[0], host_be[1]} : host_be;
               wdata_nxt = swap16(host_data_in, big_r);
               rdata_nxt = HBI_DATA_RST;
               if (is_mem || is_reg) begin
                  req_nxt   = 1'b1;
                  state_nxt = HBI_ST_REQ;
               end else begin
                  // Unmapped: complete at once, reads return zero
                  state_nxt = HBI_ST_DONE;
               end
            end
         end
         HBI_ST_REQ: begin
            if (acc_grant) begin
               req_nxt   = 1'b0;
               state_nxt = write_r ? HBI_ST_DONE : HBI_ST_RDW;
            end
         end
         HBI_ST_RDW: begin
            if (acc_rvalid) begin
               rdata_nxt = swap16(acc_rdata, big_r);
               state_nxt = HBI_ST_DONE;
            end
         end
         HBI_ST_DONE: begin
            if (!cs_act || !(rd_act || wr_act)) begin
               state_nxt = HBI_ST_IDLE;
            end
         end
      endcase
      // Wait is low while the access is pending in the core
      wait_n_nxt = !(state_nxt == HBI_ST_REQ || state_nxt == HBI_ST_RDW);
      oe_nxt     = (state_nxt == HBI_ST_DONE) && !write_nxt && cs_act && rd_act;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_r  <= HBI_ST_IDLE;
         req_r    <= 1'b0;
         write_r  <= 1'b0;
         reg_r    <= 1'b0;
         addr_r   <= HBI_ADDR_RST;
         be_r     <= HBI_BE_RST;
         wdata_r  <= HBI_DATA_RST;
         rdata_r  <= HBI_DATA_RST;
         oe_r     <= 1'b0;
         wait_n_r <= 1'b1;
      end else begin
         state_r  <= state_nxt;
         req_r    <= req_nxt;
         write_r  <= write_nxt;
         reg_r    <= reg_nxt;
         addr_r   <= addr_nxt;
         be_r     <= be_nxt;
         wdata_r  <= wdata_nxt;
         rdata_r  <= rdata_nxt;
         oe_r     <= oe_nxt;
         wait_n_r <= wait_n_nxt;
      end
   end

   assign host_data_out = rdata_r;
   assign host_data_oe  = oe_r;
   assign wait_n        = wait_n_r;
   assign acc_req       = req_r;
   assign acc_write     = write_r;
   assign acc_reg       = reg_r;
   assign acc_addr      = addr_r;
   assign acc_be        = be_r;
   assign acc_wdata     = wdata_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   grant_wait_a: assert property (req_r && !acc_grant |=> req_r && !wait_n_r)
      else $error("wait released before grant");
   write_release_a: assert property (req_r && acc_grant && write_r |=> wait_n_r && !req_r)
      else $error("write not released after grant");
   read_valid_a: assert property (state_r == HBI_ST_RDW && acc_rvalid && cs_act && rd_act
      |=> wait_n_r && rdata_r == swap16($past(acc_rdata), big_r))
      else $error("read data not presented with wait release");
   read_hold_a: assert property (state_r == HBI_ST_RDW && !acc_rvalid |=> !wait_n_r)
      else $error("wait released before read data valid");
   start_wait_a: assert property (state_r == HBI_ST_IDLE && start && (is_mem || is_reg)
      |=> !wait_n_r && req_r)
      else $error("mapped access did not assert wait");
   map_range_a: assert property (req_r |-> addr_r <= HBI_MEM_LAST || addr_r >= HBI_REG_FIRST)
      else $error("request to unmapped address");
   reg_select_a: assert property (req_r |-> reg_r == (addr_r >= HBI_REG_FIRST))
      else $error("register select mismatch");
   strap_stable_a: assert property (strap_taken_r |=> $stable(mode2_r) && $stable(big_r))
      else $error("strap changed after capture");
   mode2_rdhi_a: assert property (mode2_r && state_r == HBI_ST_IDLE && cs_act
      && strb_s[HBI_SB_RD_LO] && strb_s[HBI_SB_WR_LO] |=> state_r == HBI_ST_IDLE)
      else $error("upper read strobe started access in mode two");
   oe_drop_a: assert property (!cs_act |=> !oe_r)
      else $error("data driven without chip select");
endmodule : hbi_host_if

//--- hbi_host_model.sv
`timescale 1ns/1ps
module hbi_host_model (
   input  wire logic        clk,
   input  wire logic        wait_n,
   input  wire logic [15:0] data_wire,
   output logic      [16:1] addr_hi,
   output logic             addr_lsb,
   output logic      [15:0] wdata_drv,
   output logic             cs_n,
   output logic             wr_lo_n,
   output logic             hi_n,
   output logic             rd_lo_n,
   output logic             rd_hi_n
);
   initial begin
      {addr_hi, addr_lsb} = 17'h1FFFF;
      wdata_drv = 16'hFFFF;
      {cs_n, wr_lo_n, hi_n, rd_lo_n, rd_hi_n} = 5'h1F;
   end

   // One host cycle: strobes held until wait is released, then all lines let go
   task automatic access(input logic m2, input logic wr, input logic [16:0] a,
                         input logic [1:0] be, input logic [15:0] wd,
                         output logic [15:0] rd, output logic waited, output logic ok);
      int n;
      @(posedge clk);
      {addr_hi, addr_lsb} <= a;
      wdata_drv <= wr ? wd : ~wd;
      cs_n <= 1'b0;
      wr_lo_n <= !(wr && (m2 || be[0]));
      hi_n <= !(m2 ? be[1] : (wr && be[1]));
      rd_lo_n <= !(!wr && (m2 || be[0]));
      rd_hi_n <= !(!wr && !m2 && be[1]);
      waited = 1'b0;
      ok = 1'b1;
      for (n = 0; n < 8 && !waited; n++) begin
         @(posedge clk);
         waited = (wait_n === 1'b0);
      end
      if (waited) begin
         ok = 1'b0;
         for (n = 0; n < 200 && !ok; n++) begin
            @(posedge clk);
            ok = (wait_n === 1'b1);
         end
      end
      rd = data_wire;
      // Released address and data lines show the inverse so stale values never look valid; strobes return to idle high
      {addr_hi, addr_lsb} <= ~a;
      wdata_drv <= ~wd;
      {cs_n, wr_lo_n, hi_n, rd_lo_n, rd_hi_n} <= 5'h1F;
      repeat (5) @(posedge clk);
   endtask : access
endmodule : hbi_host_model

//--- test_generic_host_bus_interface.sv
`timescale 1ns/1ps
module test_generic_host_bus_interface;
   import hbi_pkg::*;
   localparam logic [16:0] CORNER [6] = '{17'h00000, 17'h13FFF, 17'h14000,
                                          17'h1FFDF, 17'h1FFE0, 17'h1FFFF};
   logic        clk, rstn, mode_strap_n, endian_strap, host_addr_lsb;
   logic [16:1] host_addr_in;
   logic [15:0] wdata_drv, data_wire, host_data_out, acc_wdata, acc_rdata, core_rd;
   logic        host_data_oe, chip_select_n, low_byte_write_n, high_byte_strobe_n;
   logic        low_byte_read_n, high_byte_read_n, wait_n;
   logic        acc_req, acc_write, acc_reg, acc_grant, acc_rvalid;
   logic [16:0] acc_addr;
   logic [1:0]  acc_be;
   logic [36:0] cap;
   int          errors, checks, reqs, gnt_dly, rv_dly;

   // Shared data bus: the device drives it while host_data_oe is high, the host otherwise
   assign data_wire = host_data_oe ? host_data_out : wdata_drv;

   hbi_host_if i_dut (.clk, .rstn, .mode_strap_n, .endian_strap, .host_addr_in,
      .host_addr_lsb, .host_data_in(data_wire), .host_data_out, .host_data_oe,
      .chip_select_n, .low_byte_write_n, .high_byte_strobe_n, .low_byte_read_n,
      .high_byte_read_n, .wait_n, .acc_req, .acc_write, .acc_reg, .acc_addr, .acc_be,
      .acc_wdata, .acc_grant, .acc_rdata, .acc_rvalid);

   hbi_host_model i_host (.clk, .wait_n, .data_wire, .addr_hi(host_addr_in),
      .addr_lsb(host_addr_lsb), .wdata_drv, .cs_n(chip_select_n),
      .wr_lo_n(low_byte_write_n), .hi_n(high_byte_strobe_n),
      .rd_lo_n(low_byte_read_n), .rd_hi_n(high_byte_read_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [15:0] swap(input logic [15:0] v, input logic big);
      return big ? {v[7:0], v[15:8]} : v;
   endfunction : swap

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // ------------------------------------------------------------
   // Core arbiter: grant delayed as if display refresh holds it
   // ------------------------------------------------------------
   initial begin
      acc_grant = 1'b0;
      acc_rvalid = 1'b0;
      acc_rdata = 16'h5A5A;
      forever begin
         @(posedge clk);
         acc_rdata <= ~acc_rdata;
         if (acc_req === 1'b1) begin
            repeat (gnt_dly) begin
               @(posedge clk);
               check({16'h0000, wait_n}, 17'h00000);
            end
            acc_grant <= 1'b1;
            @(posedge clk);
            acc_grant <= 1'b0;
            cap = {acc_write, acc_reg, acc_be, acc_addr, acc_wdata};
            reqs++;
            if (acc_write !== 1'b1) begin
               repeat (rv_dly) @(posedge clk);
               acc_rdata <= core_rd;
               acc_rvalid <= 1'b1;
               @(posedge clk);
               acc_rvalid <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Main sequence: every strap setting, corners then random
   // ------------------------------------------------------------
   initial begin
      logic [16:0] a;
      logic [15:0] wd, rd, er, m;
      logic [1:0]  be;
      logic        wr, m2, big, waited, ok, mapped;
      int          n, cfg, r0;
      errors = 0;
      checks = 0;
      reqs = 0;
      gnt_dly = 0;
      rv_dly = 0;
      core_rd = 16'h0000;
      rstn = 1'b0;
      mode_strap_n = 1'b0;
      endian_strap = 1'b0;
      void'($urandom(45912));
      for (cfg = 0; cfg < 4; cfg++) begin
         m2 = cfg[0];
         big = cfg[1];
         @(posedge clk);
         rstn <= 1'b0;
         mode_strap_n <= m2;
         endian_strap <= big;
         repeat (16) @(posedge clk);
         rstn <= 1'b1;
         repeat (3) @(posedge clk);
         for (n = 0; n < 16; n++) begin
            a = n[0] ? 17'h1FFE0 + 17'($urandom_range(31)) : 17'($urandom_range(32'h13FFF));
            if (n < 6) a = CORNER[n];
            be = 2'($urandom_range(1, 3));
            if (m2) a[0] = !be[0];
            wr = 1'($urandom);
            wd = 16'($urandom);
            core_rd = 16'($urandom);
            gnt_dly = $urandom_range(0, 5);
            rv_dly = $urandom_range(0, 3);
            m = {{8{be[1]}}, {8{be[0]}}};
            mapped = (a <= HBI_MEM_LAST) || (a >= HBI_REG_FIRST);
            r0 = reqs;
            i_host.access(m2, wr, a, be, wd, rd, waited, ok);
            if (ok !== 1'b1) begin
               errors++;
               results();
            end
            check({16'h0000, waited}, {16'h0000, mapped});
            check(17'(reqs - r0), {16'h0000, mapped});
            if (mapped) begin
               check({16'h0000, cap[36]}, {16'h0000, wr});
               check({16'h0000, cap[35]}, {16'h0000, a >= HBI_REG_FIRST});
               check({15'h0000, cap[34:33]}, {15'h0000, big ? {be[0], be[1]} : be});
               check(cap[32:16], a);
               if (wr) check({1'b0, cap[15:0] & swap(m, big)}, {1'b0, swap(wd & m, big)});
            end
            er = mapped ? swap(core_rd, big) : 16'h0000;
            if (!wr) check({1'b0, rd & m}, {1'b0, er & m});
         end
         if (m2) begin
            // Upper read strobe alone must start nothing in mode two
            r0 = reqs;
            i_host.access(1'b0, 1'b0, 17'h00000, 2'h2, wd, rd, waited, ok);
            check({16'h0000, waited}, 17'h00000);
            check(17'(reqs - r0), 17'h00000);
            check({1'b0, rd}, {1'b0, ~wd});
         end
      end
      results();
   end
endmodule : test_generic_host_bus_interface
